// >>> design/pitc_core.sv
// Top of the interval timer: host port, presets, snapshots and channels.
`timescale 1ns/10ps
module pitc_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_sel_lo,
  input wire logic port_sel_hi,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic tick_in_zero,
  input wire logic tick_in_one,
  input wire logic tick_in_two,
  input wire logic enable_in_zero,
  input wire logic enable_in_one,
  input wire logic enable_in_two,
  output logic timer_pin_zero,
  output logic timer_pin_one,
  output logic timer_pin_two
);

  // ***************************************************************
  // Pin resampling.
  // ***************************************************************
  pitc_pkg::pitc_pins_s raw, s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

  assign raw.data = data_in;
  assign raw.addr = {port_sel_hi, port_sel_lo};
  assign raw.cs_n = chip_sel_n;
  assign raw.rd_n = rd_n;
  assign raw.wr_n = wr_n;
  assign raw.tick = {tick_in_two, tick_in_one, tick_in_zero};
  assign raw.gate = {enable_in_two, enable_in_one, enable_in_zero};

  // Passes all pins through a two-stage resampler and one history stage.
  always_comb begin
    s1_d = raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Registers the resampling pipeline.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  logic wr_done, rd_done, rd_act;
  logic [1:0] wa, ra;
  logic [7:0] wdat;

  // Strobe trailing edges only count while chip select was low.
  assign wr_done = s2_q.wr_n & ~s3_q.wr_n & ~s3_q.cs_n;
  assign rd_done = s2_q.rd_n & ~s3_q.rd_n & ~s3_q.cs_n;
  assign rd_act = ~s2_q.cs_n & ~s2_q.rd_n;
  assign wa = s3_q.addr;
  assign ra = s2_q.addr;
  assign wdat = s3_q.data;

  // ***************************************************************
  // Per-channel host state.
  // ***************************************************************
  logic [5:0] cw_q[3], cw_d[3];
  logic [15:0] cr_q[3], cr_d[3];
  logic [15:0] ol_q[3], ol_d[3];
  logic [7:0] st_q[3], st_d[3];
  logic wrhi_q[3], wrhi_d[3], rdhi_q[3], rdhi_d[3];
  logic olh_q[3], olh_d[3], sth_q[3], sth_d[3];
  logic prog_q[3], prog_d[3], load_q[3], load_d[3];
  logic first_q[3], first_d[3];
  logic [7:0] dout_q, dout_d;
  logic doe_n_q, doe_n_d;
  logic [15:0] ce_w[3];
  logic out_w[3], nul_w[3];
  logic [1:0] rw;

  // Decodes host writes and reads into per-channel state changes.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cw_d[i] = cw_q[i];
      cr_d[i] = cr_q[i];
      st_d[i] = st_q[i];
      wrhi_d[i] = wrhi_q[i];
      rdhi_d[i] = rdhi_q[i];
      olh_d[i] = olh_q[i];
      sth_d[i] = sth_q[i];
      prog_d[i] = 1'b0;
      load_d[i] = 1'b0;
      first_d[i] = 1'b0;
      ol_d[i] = olh_q[i] ? ol_q[i] : ce_w[i];
    end
    rw = 2'h0;
    if (wr_done && wa == pitc_pkg::PORT_CW) begin
      if (wdat[7:pitc_pkg::CW_SC_LO] == pitc_pkg::SC_READBACK) begin
        for (int i = 0; i < 3; i++) begin
          if (wdat[pitc_pkg::RB_SEL_LO + i]) begin
            if (!wdat[pitc_pkg::RB_COUNT_N] && !olh_q[i]) begin
              ol_d[i] = ce_w[i];
              olh_d[i] = 1'b1;
            end
            if (!wdat[pitc_pkg::RB_STATUS_N] && !sth_q[i]) begin
              st_d[i] = {out_w[i], nul_w[i], cw_q[i]};
              sth_d[i] = 1'b1;
            end
          end
        end
      end else begin
        for (int i = 0; i < 3; i++) begin
          if (wdat[7:pitc_pkg::CW_SC_LO] == 2'(i)) begin
            if (wdat[5:pitc_pkg::CW_RW_LO] == pitc_pkg::RW_LATCH) begin
              if (!olh_q[i]) begin
                ol_d[i] = ce_w[i];
                olh_d[i] = 1'b1;
              end
            end else begin
              cw_d[i] = wdat[pitc_pkg::CW_CFG_W-1:0];
              cr_d[i] = pitc_pkg::COUNT_RST;
              wrhi_d[i] = 1'b0;
              rdhi_d[i] = 1'b0;
              olh_d[i] = 1'b0;
              sth_d[i] = 1'b0;
              prog_d[i] = 1'b1;
            end
          end
        end
      end
    end else if (wr_done) begin
      for (int i = 0; i < 3; i++) begin
        if (wa == 2'(i)) begin
          rw = cw_q[i][5:pitc_pkg::CW_RW_LO];
          if (rw == pitc_pkg::RW_LSB ||
              (rw == pitc_pkg::RW_BOTH && !wrhi_q[i])) begin
            cr_d[i][7:0] = wdat;
          end else begin
            cr_d[i][15:8] = wdat;
          end
          if (rw == pitc_pkg::RW_BOTH && !wrhi_q[i]) begin
            wrhi_d[i] = 1'b1;
            first_d[i] = 1'b1;
          end else if (rw != pitc_pkg::RW_LATCH) begin
            wrhi_d[i] = 1'b0;
            load_d[i] = 1'b1;
          end
        end
      end
    end
    if (rd_done) begin
      for (int i = 0; i < 3; i++) begin
        if (s3_q.addr == 2'(i)) begin
          if (sth_q[i]) begin
            sth_d[i] = 1'b0;
          end else if (cw_q[i][5:pitc_pkg::CW_RW_LO] ==
                       pitc_pkg::RW_BOTH && !rdhi_q[i]) begin
            rdhi_d[i] = 1'b1;
          end else begin
            rdhi_d[i] = 1'b0;
            olh_d[i] = 1'b0;
          end
        end
      end
    end
    dout_d = pitc_pkg::BYTE_RST;
    doe_n_d = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (rd_act && ra == 2'(i)) begin
        doe_n_d = 1'b0;
        if (sth_q[i]) begin
          dout_d = st_q[i];
        end else if (cw_q[i][5:pitc_pkg::CW_RW_LO] == pitc_pkg::RW_MSB ||
                     (cw_q[i][5:pitc_pkg::CW_RW_LO] == pitc_pkg::RW_BOTH &&
                      rdhi_q[i])) begin
          dout_d = ol_q[i][15:8];
        end else begin
          dout_d = ol_q[i][7:0];
        end
      end
    end
  end

  // Registers the per-channel host state and the data port.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        cw_q[i] <= pitc_pkg::CFG_RST;
        cr_q[i] <= pitc_pkg::COUNT_RST;
        ol_q[i] <= pitc_pkg::COUNT_RST;
        st_q[i] <= pitc_pkg::BYTE_RST;
        wrhi_q[i] <= 1'b0;
        rdhi_q[i] <= 1'b0;
        olh_q[i] <= 1'b0;
        sth_q[i] <= 1'b0;
        prog_q[i] <= 1'b0;
        load_q[i] <= 1'b0;
        first_q[i] <= 1'b0;
      end
      dout_q <= pitc_pkg::BYTE_RST;
      doe_n_q <= 1'b1;
    end else begin
      for (int i = 0; i < 3; i++) begin
        cw_q[i] <= cw_d[i];
        cr_q[i] <= cr_d[i];
        ol_q[i] <= ol_d[i];
        st_q[i] <= st_d[i];
        wrhi_q[i] <= wrhi_d[i];
        rdhi_q[i] <= rdhi_d[i];
        olh_q[i] <= olh_d[i];
        sth_q[i] <= sth_d[i];
        prog_q[i] <= prog_d[i];
        load_q[i] <= load_d[i];
        first_q[i] <= first_d[i];
      end
      dout_q <= dout_d;
      doe_n_q <= doe_n_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe_n = doe_n_q;

  // ***************************************************************
  // Counting channels.
  // ***************************************************************
  pitc_ctr_if ch[3] ();

  // Joins each channel to its host state and resampled pins.
  for (genvar g = 0; g < 3; g++) begin : g_ch
    assign ch[g].prog = prog_q[g];
    assign ch[g].load = load_q[g];
    assign ch[g].first = first_q[g];
    assign ch[g].tick_rise = s2_q.tick[g] & ~s3_q.tick[g];
    assign ch[g].tick_fall = ~s2_q.tick[g] & s3_q.tick[g];
    assign ch[g].gate_lvl = s2_q.gate[g];
    assign ch[g].gate_rise = s2_q.gate[g] & ~s3_q.gate[g];
    assign ch[g].mode = cw_q[g][3:1];
    assign ch[g].bcd = cw_q[g][0];
    assign ch[g].cr = cr_q[g];
    assign ce_w[g] = ch[g].ce;
    assign out_w[g] = ch[g].out;
    assign nul_w[g] = ch[g].nul;

    pitc_counter u_ctr (
      .mclk(mclk),
      .rst(rst),
      .link(ch[g])
    );
  end

  assign timer_pin_zero = out_w[0];
  assign timer_pin_one = out_w[1];
  assign timer_pin_two = out_w[2];

endmodule : pitc_core

// >>> design/pitc_pkg.sv
// Package of shared constants and types for the interval timer core.
package pitc_pkg;

  // ***************************************************************
  // Port map and control word layout.
  // ***************************************************************
  localparam logic [1:0] PORT_CTR0 = 2'h0;
  localparam logic [1:0] PORT_CTR1 = 2'h1;
  localparam logic [1:0] PORT_CTR2 = 2'h2;
  localparam logic [1:0] PORT_CW = 2'h3;
  localparam int CW_SC_LO = 6;
  localparam int CW_RW_LO = 4;
  localparam int CW_CFG_W = 6;
  localparam logic [1:0] SC_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam int RB_COUNT_N = 5;
  localparam int RB_STATUS_N = 4;
  localparam int RB_SEL_LO = 1;

  // ***************************************************************
  // Counting modes and reset values.
  // ***************************************************************
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_TWO = 16'h0002;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] CFG_RST = 6'h00;

  // One sampled copy of every host and counter input pin.
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] addr;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] tick;
    logic [2:0] gate;
  } pitc_pins_s;

endpackage : pitc_pkg

// >>> design/pitc_ctr_if.sv
// Interface between the bus hub and one counter channel.
`timescale 1ns/10ps
interface pitc_ctr_if;
  logic prog;
  logic load;
  logic first;
  logic tick_rise;
  logic tick_fall;
  logic gate_lvl;
  logic gate_rise;
  logic [2:0] mode;
  logic bcd;
  logic [15:0] cr;
  logic [15:0] ce;
  logic out;
  logic nul;

  modport hub (output prog, load, first, tick_rise, tick_fall, gate_lvl,
    gate_rise, mode, bcd, cr, input ce, out, nul);
  modport ctr (input prog, load, first, tick_rise, tick_fall, gate_lvl,
    gate_rise, mode, bcd, cr, output ce, out, nul);
endinterface : pitc_ctr_if

// >>> design/pitc_counter.sv
// One counting channel: counting element, gate logic and output pin.
`timescale 1ns/10ps
module pitc_counter (
  input wire logic mclk,
  input wire logic rst,
  pitc_ctr_if.ctr link
);

  // ***************************************************************
  // Decrement helper.
  // ***************************************************************

  // Steps one count down, digit by digit in decimal mode.
  function automatic logic [15:0] pitc_dec(input logic [15:0] v,
                                           input logic b);
    logic [15:0] r;
    logic brw;
    r = v;
    brw = 1'b1;
    if (!b) begin
      r = v - pitc_pkg::COUNT_ONE;
    end else begin
      for (int j = 0; j < 4; j++) begin
        if (brw) begin
          if (r[4*j +: 4] == 4'h0) begin
            r[4*j +: 4] = 4'h9;
          end else begin
            r[4*j +: 4] = r[4*j +: 4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : pitc_dec

  // ***************************************************************
  // Channel state.
  // ***************************************************************
  logic [15:0] ce_q, ce_d;
  logic out_q, out_d, nul_q, nul_d, pend_q, pend_d, stop_q, stop_d;
  logic run_q, run_d, cv_q, cv_d, trig_q, trig_d;
  logic gsmp_q, gsmp_d, tsmp_q, tsmp_d;
  logic [2:0] m;
  logic lvl_mode, edge_mode, en;
  logic [15:0] dec1, dec2;

  // Modes six and seven behave as two and three.
  assign m = link.mode[1] ? {1'b0, link.mode[1:0]} : link.mode;
  assign lvl_mode = (m != pitc_pkg::MODE_1) && (m != pitc_pkg::MODE_5);
  assign edge_mode = (m != pitc_pkg::MODE_0) && (m != pitc_pkg::MODE_4);
  assign dec1 = pitc_dec(ce_q, link.bcd);
  assign dec2 = pitc_dec(dec1, link.bcd);
  assign en = run_q && !stop_q && (!lvl_mode || gsmp_q);

  // Computes the next channel state from tick, gate and host events.
  always_comb begin
    ce_d = ce_q;
    out_d = out_q;
    nul_d = nul_q;
    pend_d = pend_q;
    stop_d = stop_q;
    run_d = run_q;
    cv_d = cv_q;
    gsmp_d = gsmp_q;
    tsmp_d = tsmp_q;
    trig_d = link.gate_rise | (trig_q & ~link.tick_rise);
    if (link.tick_rise) begin
      gsmp_d = link.gate_lvl;
      tsmp_d = trig_q;
    end
    if (link.tick_fall) begin
      if (pend_q || (edge_mode && tsmp_q && cv_q)) begin
        ce_d = link.cr;
        pend_d = 1'b0;
        nul_d = 1'b0;
        run_d = 1'b1;
        tsmp_d = 1'b0;
        if (m == pitc_pkg::MODE_1) begin
          out_d = 1'b0;
        end else if (m != pitc_pkg::MODE_0) begin
          out_d = 1'b1;
        end
      end else if (en) begin
        case (m)
          pitc_pkg::MODE_2: begin
            if (ce_q == pitc_pkg::COUNT_ONE) begin
              ce_d = link.cr;
              nul_d = 1'b0;
              out_d = 1'b1;
            end else begin
              ce_d = dec1;
              out_d = (dec1 != pitc_pkg::COUNT_ONE);
            end
          end
          pitc_pkg::MODE_3: begin
            if (ce_q == pitc_pkg::COUNT_ONE ||
                ce_q == pitc_pkg::COUNT_TWO) begin
              ce_d = link.cr;
              nul_d = 1'b0;
              out_d = ~out_q;
            end else begin
              ce_d = dec2;
            end
          end
          pitc_pkg::MODE_0, pitc_pkg::MODE_1: begin
            ce_d = dec1;
            if (dec1 == pitc_pkg::COUNT_RST) begin
              out_d = 1'b1;
            end
          end
          default: begin
            ce_d = dec1;
            out_d = (dec1 != pitc_pkg::COUNT_RST);
          end
        endcase
      end
    end
    // A low gate forces the periodic modes high at once.
    if ((m == pitc_pkg::MODE_2 || m == pitc_pkg::MODE_3) &&
        !link.gate_lvl) begin
      out_d = 1'b1;
    end
    if (link.load) begin
      nul_d = 1'b1;
      cv_d = 1'b1;
      stop_d = 1'b0;
      // Trigger-only modes stay armed until a gate rising edge loads them.
      if (lvl_mode && (!edge_mode || !run_q)) begin
        pend_d = 1'b1;
      end
      if (m == pitc_pkg::MODE_0) begin
        out_d = 1'b0;
      end
    end
    if (link.first && m == pitc_pkg::MODE_0) begin
      out_d = 1'b0;
      stop_d = 1'b1;
    end
    if (link.prog) begin
      out_d = (m != pitc_pkg::MODE_0);
      nul_d = 1'b1;
      pend_d = 1'b0;
      stop_d = 1'b0;
      run_d = 1'b0;
      cv_d = 1'b0;
      trig_d = 1'b0;
      tsmp_d = 1'b0;
    end
  end

  // Registers the channel state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ce_q <= pitc_pkg::COUNT_RST;
      out_q <= 1'b0;
      nul_q <= 1'b0;
      pend_q <= 1'b0;
      stop_q <= 1'b0;
      run_q <= 1'b0;
      cv_q <= 1'b0;
      trig_q <= 1'b0;
      gsmp_q <= 1'b0;
      tsmp_q <= 1'b0;
    end else begin
      ce_q <= ce_d;
      out_q <= out_d;
      nul_q <= nul_d;
      pend_q <= pend_d;
      stop_q <= stop_d;
      run_q <= run_d;
      cv_q <= cv_d;
      trig_q <= trig_d;
      gsmp_q <= gsmp_d;
      tsmp_q <= tsmp_d;
    end
  end

  assign link.ce = ce_q;
  assign link.out = out_q;
  assign link.nul = nul_q;

endmodule : pitc_counter

// >>> testbench/pitc_core_chk.sv
// Concurrent checks on the interval timer core's pins.
`timescale 1ns/10ps
module pitc_core_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_sel_lo,
  input wire logic port_sel_hi,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic tick_in_zero,
  input wire logic tick_in_one,
  input wire logic tick_in_two,
  input wire logic enable_in_zero,
  input wire logic enable_in_one,
  input wire logic enable_in_two,
  input wire logic timer_pin_zero,
  input wire logic timer_pin_one,
  input wire logic timer_pin_two
);
  // ***************************************************************
  // Bus port and counter pin checks.
  // ***************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // The control word register is addressed with chip select low.
  logic cw_hit;
  assign cw_hit = !chip_sel_n && port_sel_hi && port_sel_lo;

  cs_idle_float_a: assert property (chip_sel_n [*5] |-> data_oe_n)
    else $error("data port driven while chip select idle");
  rd_idle_float_a: assert property (rd_n [*5] |-> data_oe_n)
    else $error("data port driven with no read strobe");
  cw_read_float_a: assert property ((cw_hit && !rd_n) [*5] |-> data_oe_n)
    else $error("data port driven on a control word read");
  read_answer_a: assert property ($fell(rd_n) && !chip_sel_n &&
    !(port_sel_hi && port_sel_lo) |-> ##[1:4] !data_oe_n)
    else $error("counter read not answered in time");
  oe_release_a: assert property ($rose(rd_n) |-> ##[1:5] data_oe_n)
    else $error("data port not released after read");
  idle_zero_a: assert property (data_oe_n |-> data_out == 8'h00)
    else $error("read data not cleared while idle");
  data_hold_a: assert property (!data_oe_n && !$past(data_oe_n)
    |-> $stable(data_out))
    else $error("read byte changed during the read");
  mode0_init_a: assert property ($rose(wr_n) && cw_hit &&
    data_in[7:6] == 2'h0 && data_in[5:4] != 2'h0 && data_in[3:1] == 3'h0
    |-> ##[2:6] !timer_pin_zero)
    else $error("mode zero control word did not clear the pin");
  mode2_init_a: assert property ($rose(wr_n) && cw_hit &&
    data_in[7:6] == 2'h1 && data_in[5:4] != 2'h0 && data_in[2:1] == 2'h2
    |-> ##[2:6] timer_pin_one)
    else $error("mode two control word did not set the pin");
endmodule : pitc_core_chk

bind pitc_core pitc_core_chk i_chk (
  .mclk(mclk), .rst(rst), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
  .wr_n(wr_n), .port_sel_lo(port_sel_lo), .port_sel_hi(port_sel_hi),
  .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .tick_in_zero(tick_in_zero), .tick_in_one(tick_in_one),
  .tick_in_two(tick_in_two), .enable_in_zero(enable_in_zero),
  .enable_in_one(enable_in_one), .enable_in_two(enable_in_two),
  .timer_pin_zero(timer_pin_zero), .timer_pin_one(timer_pin_one),
  .timer_pin_two(timer_pin_two)
);

// >>> testbench/pitc_host_model.sv
// Host bus model that drives the timer port and resolves the data pins.
`timescale 1ns/10ps
module pitc_host_model (
  input wire logic mclk,
  output logic chip_sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_sel_lo,
  output logic port_sel_hi,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  logic drv = 1'b0;
  logic [7:0] dat = 8'h00;
  logic [7:0] last_q = 8'h00;

  // Pins idle with both strobes and the select high.
  initial begin
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {port_sel_hi, port_sel_lo} = 2'h0;
  end

  // An undriven data line shows the inverse of its last level.
  assign data_in = drv ? dat : (!data_oe_n ? data_out : ~last_q);
  always @(posedge mclk) begin
    last_q <= data_in;
  end

  // Write cycle: select and data are held well around the strobe.
  task automatic bus_write(input logic cs_n, input logic [1:0] a,
                           input logic [7:0] v);
    @(posedge mclk);
    #1;
    chip_sel_n = cs_n;
    {port_sel_hi, port_sel_lo} = a;
    dat = v;
    drv = 1'b1;
    @(posedge mclk);
    #1;
    wr_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    wr_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chip_sel_n = 1'b1;
    drv = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : bus_write

  // Read cycle: the strobe stays low until the port is driven or ten clocks pass.
  task automatic bus_read(input logic [1:0] a, output logic [7:0] v,
                          output bit got);
    got = 1'b0;
    v = 8'h00;
    @(posedge mclk);
    #1;
    chip_sel_n = 1'b0;
    {port_sel_hi, port_sel_lo} = a;
    rd_n = 1'b0;
    for (int n = 0; n < 10 && !got; n++) begin
      @(posedge mclk);
      if (data_oe_n === 1'b0) begin
        got = 1'b1;
        v = data_in;
      end
    end
    #1;
    rd_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chip_sel_n = 1'b1;
  endtask : bus_read
endmodule : pitc_host_model

// >>> testbench/pitc_core_bench.sv
// Self-checking bench for the interval timer core.
`timescale 1ns/10ps
module pitc_core_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic chip_sel_n, rd_n, wr_n, port_sel_lo, port_sel_hi, data_oe_n;
  logic [7:0] data_in, data_out, b;
  logic [2:0] tick = 3'h0;
  logic [2:0] gate = 3'h0;
  logic [2:0] pin;
  logic [15:0] w, v;
  bit got;
  int errors = 0;
  int samples_checked = 0;
  int ce [3];
  int cr [3];
  int md [3];
  bit pend [3];
  bit mpin [3];

  // ***************************************************************
  // Clock, design and host model.
  // ***************************************************************
  always #10 mclk = ~mclk;

  pitc_core i_dut (.mclk(mclk), .rst(rst), .chip_sel_n(chip_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_sel_lo(port_sel_lo),
    .port_sel_hi(port_sel_hi), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .tick_in_zero(tick[0]), .tick_in_one(tick[1]),
    .tick_in_two(tick[2]), .enable_in_zero(gate[0]),
    .enable_in_one(gate[1]), .enable_in_two(gate[2]),
    .timer_pin_zero(pin[0]), .timer_pin_one(pin[1]), .timer_pin_two(pin[2]));
  pitc_host_model i_host (.mclk(mclk), .chip_sel_n(chip_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_sel_lo(port_sel_lo),
    .port_sel_hi(port_sel_hi), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n));

  // Compares one result and counts it.
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // Bus helpers; a counter read that is never answered ends the run.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_host.bus_write(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    i_host.bus_read(a, d, got);
    if (a != 2'h3 && !got) begin
      errors++;
      tally_and_finish();
    end
  endtask : rd
  task automatic rd16(input logic [1:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a, d[15:8]);
  endtask : rd16

  // One count-clock pulse, then the reference model steps.
  task automatic pulse(input int k);
    @(posedge mclk);
    #1;
    tick[k] = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    tick[k] = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    if (pend[k]) begin
      ce[k] = cr[k];
      pend[k] = 1'b0;
    end else if (md[k] == 2 && gate[k]) begin
      ce[k] = (ce[k] == 1) ? cr[k] : ce[k] - 1;
    end else if (md[k] == 0 && gate[k]) begin
      ce[k] = (ce[k] + 65535) % 65536;
      mpin[k] |= (ce[k] == 0);
    end
    if (md[k] == 0) check("pin", 16'(pin[k]), 16'(mpin[k]));
  endtask : pulse

  // ***************************************************************
  // Main sequence.
  // ***************************************************************
  initial begin
    void'($urandom(32'h9f0d_2bd6));
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    check("oe reset", 16'(data_oe_n), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      wr(2'h3, 8'(k << 6) | 8'h34);
      md[k] = 2;
    end
    check("pins mode two", 16'(pin), 16'h0007);
    wr(2'h3, 8'h30);
    md[0] = 0;
    check("pin0 mode zero", 16'(pin), 16'h0006);
    i_host.bus_write(1'b1, 2'h3, 8'h70);
    check("deselected write", 16'(pin), 16'h0006);
    gate = 3'h7;
    wr(2'h0, 8'h00);
    wr(2'h0, 8'h00);
    cr[0] = 0;
    pend[0] = 1'b1;
    pulse(0);
    pulse(0);
    wr(2'h3, 8'h00);
    v = 16'(ce[0]);
    pulse(0);
    wr(2'h3, 8'h00);
    rd16(2'h0, w);
    check("first latch", w, v);
    rd16(2'h0, w);
    check("tracking", w, 16'(ce[0]));
    v = 16'($urandom_range(32'h0000_ffff, 32'h0000_0100));
    wr(2'h0, v[7:0]);
    wr(2'h0, v[15:8]);
    cr[0] = v;
    pend[0] = 1'b1;
    wr(2'h3, 8'he2);
    rd(2'h0, b);
    check("status", 16'(b), 16'({mpin[0], 1'b1, 6'h30}));
    pulse(0);
    wr(2'h3, 8'he2);
    rd(2'h0, b);
    check("status", 16'(b), 16'({mpin[0], 1'b0, 6'h30}));
    wr(2'h3, 8'h00);
    rd16(2'h0, w);
    check("loaded count", w, v);
    wr(2'h3, 8'h10);
    wr(2'h0, 8'h03);
    cr[0] = 3;
    pend[0] = 1'b1;
    repeat (5) pulse(0);
    wr(2'h3, 8'h00);
    rd(2'h0, b);
    check("wrap", 16'(b), 16'(ce[0] % 256));
    gate[1] = 1'b0;
    wr(2'h3, 8'h50);
    md[1] = 0;
    wr(2'h1, 8'h05);
    cr[1] = 5;
    pend[1] = 1'b1;
    repeat (3) pulse(1);
    wr(2'h3, 8'h40);
    rd(2'h1, b);
    check("gate low", 16'(b), 16'(ce[1]));
    wr(2'h3, 8'h94);
    wr(2'h2, 8'h03);
    cr[2] = 3;
    gate[2] = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    gate[2] = 1'b1;
    pend[2] = 1'b1;
    repeat (4) pulse(2);
    wr(2'h3, 8'h80);
    rd(2'h2, b);
    check("reload", 16'(b), 16'(ce[2]));
    // Decimal count from the top wraps to all nines.
    wr(2'h3, 8'hb1);
    md[2] = 0;
    wr(2'h2, 8'h00);
    wr(2'h2, 8'h00);
    cr[2] = 0;
    pend[2] = 1'b1;
    repeat (2) pulse(2);
    wr(2'h3, 8'h80);
    rd16(2'h2, w);
    check("decimal wrap", w, 16'h9999);
    wr(2'h3, 8'h52);
    md[1] = 1;
    wr(2'h1, 8'h04);
    check("armed", 16'(pin[1]), 16'h0001);
    pulse(1);
    check("no trigger", 16'(pin[1]), 16'h0001);
    gate[1] = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    gate[1] = 1'b0;
    pulse(1);
    check("one shot", 16'(pin[1]), 16'h0000);
    rd(2'h3, b);
    check("control read", 16'(got), 16'h0000);
    tally_and_finish();
  end
endmodule : pitc_core_bench
